// file: rtl/vintarb_cfg.svh
// vintarb_cfg.svh: constants of the vectored interrupt arbiter
// assumes a core that runs one instruction cycle per ref_clk cycle
//
// How it works
// - every acknowledgement ends by loading the program counter with 00ff hex
// - software trap ranks highest, default vector-select entry ranks lowest
// - each maskable source has enable and pending bits; events set pending
// - maskable taken only with enable, global enable and no trap pending
// - conditions checked at instruction start; best rank wins, others wait
// - reset clears all pending flags, enables and global enable
// - enabling an already pending source with global enable set takes it
// - acknowledge only at the next normal instruction start, after any skip
// - maskable acknowledge clears global enable; every acknowledge pushes return address, loads 00ff
// - the acknowledge sequence lasts seven instruction cycles
// - software setting global enable in status register allows nesting
// - return-from-irq sets global enable and pops; pending ones follow at once
// - no acknowledgement while in boot rom; global enable left alone
// - vector select jumps through the best enabled and pending source's entry
// - table at top of vector-select block, next block if at last byte
// - vector is 15 bits, high byte at the lower address
// - lowest rank at e0/e1, each rank one pair up, trap at fe/ff
// - vector select with nothing active uses the default entry
// - a maskable source is active only with enable and pending both set
// - low pc byte replaced by even slot offset, upper byte kept (plus one at last byte), then loaded
// - trap sets trap pending flag, readable in status; only clear-trap or reset clear it
`ifndef VINTARB_CFG_SVH
`define VINTARB_CFG_SVH

`define VIA_NSRC 13
`define VIA_NSLOT 16
`define VIA_AW 15
`define VIA_RAW 3
`define VIA_SVC_ADDR 15'h00ff
`define VIA_ACK_CYCLES 3'h7
`define VIA_TBL_BASE 8'he0
`define VIA_BLK_LAST 8'hff
`define VIA_TRAP_SLOT 4'hf
`define VIA_DEF_SLOT 4'h0
// register offsets
`define VIA_REG_EN_LO 3'h0
`define VIA_REG_EN_HI 3'h1
`define VIA_REG_PND_LO 3'h2
`define VIA_REG_PND_HI 3'h3
`define VIA_REG_PSR 3'h4
`define VIA_REG_STAT 3'h5
// field positions
`define VIA_PSR_GIE 0
`define VIA_STAT_TRAP 0
`define VIA_STAT_BUSY 1
`define VIA_HI_W 5

`endif

// file: rtl/vintarb_pkg.sv
// vintarb_pkg.sv: types of the vectored interrupt arbiter
// assumes vintarb_cfg.svh is compiled alongside
package vintarb_pkg;
  typedef enum logic [2:0] {
    VIA_IDLE,
    VIA_ACK,
    VIA_VEC_HI,
    VIA_VEC_LO,
    VIA_VEC_JMP
  } vintarb_state_t;
endpackage

// file: rtl/vintarb_flags.sv
// vintarb_flags.sv: bank of software-writable flags that hardware may set
// assumes one clock and asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "vintarb_cfg.svh"
module vintarb_flags
  import vintarb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // hardware set and software write
  input wire logic [`VIA_NSRC-1:0] set_i,
  input wire logic [`VIA_NSRC-1:0] wr_en,
  input wire logic [`VIA_NSRC-1:0] wr_val,
  // flag state
  output logic [`VIA_NSRC-1:0] flag_q
);

  genvar i;
  generate
    for (i = 0; i < `VIA_NSRC; i = i + 1) begin : g_flag
      wire logic flag_d;
      // set wins over a same-cycle software clear
      assign flag_d = set_i[i] | (wr_en[i] ? wr_val[i] : flag_q[i]);
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          flag_q[i] <= 1'b0;
        end else begin
          flag_q[i] <= flag_d;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// file: rtl/vintarb_rank.sv
// vintarb_rank.sv: fixed-rank arbiter over the sixteen vector slots
// assumes slot 15 is the trap and slot 0 the default entry
`timescale 1ns/1ns
`default_nettype none
`include "vintarb_cfg.svh"
module vintarb_rank
  import vintarb_pkg::*;
(
  // requests, one per slot
  input wire logic [`VIA_NSLOT-1:0] req,
  // winning slot
  output logic [3:0] slot
);

  // highest set bit wins; none set gives the default slot
  function automatic logic [3:0] top_slot(input logic [`VIA_NSLOT-1:0] r);
    logic [3:0] s;
    s = `VIA_DEF_SLOT;
    for (int k = 0; k < `VIA_NSLOT; k++) begin
      if (r[k]) begin
        s = 4'(k);
      end
    end
    return s;
  endfunction

  assign slot = top_slot(req);

endmodule
`default_nettype wire

// file: rtl/vintarb.sv
// vintarb.sv: vectored interrupt arbiter top
// assumes the core signals instruction starts, vector select, return and
// trap instructions as one-cycle pulses, and answers program reads next cycle
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "vintarb_cfg.svh"
module vintarb
  import vintarb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [`VIA_RAW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral interrupt conditions
  input wire logic [`VIA_NSRC-1:0] src_event,
  // core instruction flow
  input wire logic instr_start,
  input wire logic skip_next,
  input wire logic in_boot_rom,
  input wire logic [`VIA_AW-1:0] cur_pc,
  input wire logic trap_exec,
  input wire logic vis_exec,
  input wire logic [`VIA_AW-1:0] vis_pc,
  input wire logic return_from_irq_instruction_exec,
  input wire logic clear_trap_pending_instruction_exec,
  // stack and program counter requests
  output logic push_req,
  output logic [`VIA_AW-1:0] push_addr,
  output logic pop_req,
  output logic pc_load,
  output logic [`VIA_AW-1:0] pc_load_addr,
  output logic ack_busy,
  // program memory read for vector fetch
  output logic pm_rd_req,
  output logic [`VIA_AW-1:0] pm_rd_addr,
  input wire logic [7:0] pm_rd_data
);

  ////////////////////////////////////////////////////////////////////////
  // state
  vintarb_state_t state_q;
  logic [2:0] ack_cnt_q;
  logic gie_q;
  logic trap_pnd_q;
  logic trap_due_q;
  logic [7:0] vec_hi_q;
  logic [`VIA_AW-1:0] vec_addr_q;
  logic [`VIA_NSRC-1:0] en_q;
  logic [`VIA_NSRC-1:0] pnd_q;

  ////////////////////////////////////////////////////////////////////////
  // register decode
  wire logic wr_en_lo;
  wire logic wr_en_hi;
  wire logic wr_pnd_lo;
  wire logic wr_pnd_hi;
  wire logic wr_psr;
  wire logic [`VIA_NSRC-1:0] en_wmask;
  wire logic [`VIA_NSRC-1:0] pnd_wmask;
  wire logic [`VIA_NSRC-1:0] wr_val;
  wire logic [7:0] rd_mux;

  assign wr_en_lo = reg_wr && (reg_addr == `VIA_REG_EN_LO);
  assign wr_en_hi = reg_wr && (reg_addr == `VIA_REG_EN_HI);
  assign wr_pnd_lo = reg_wr && (reg_addr == `VIA_REG_PND_LO);
  assign wr_pnd_hi = reg_wr && (reg_addr == `VIA_REG_PND_HI);
  assign wr_psr = reg_wr && (reg_addr == `VIA_REG_PSR);
  assign en_wmask = {{`VIA_HI_W{wr_en_hi}}, {8{wr_en_lo}}};
  assign pnd_wmask = {{`VIA_HI_W{wr_pnd_hi}}, {8{wr_pnd_lo}}};
  assign wr_val = {reg_wdata[`VIA_HI_W-1:0], reg_wdata};

  assign rd_mux =
    (reg_addr == `VIA_REG_EN_LO) ? en_q[7:0] :
    (reg_addr == `VIA_REG_EN_HI) ? {3'h0, en_q[`VIA_NSRC-1:8]} :
    (reg_addr == `VIA_REG_PND_LO) ? pnd_q[7:0] :
    (reg_addr == `VIA_REG_PND_HI) ? {3'h0, pnd_q[`VIA_NSRC-1:8]} :
    (reg_addr == `VIA_REG_PSR) ? {7'h00, gie_q} :
    (reg_addr == `VIA_REG_STAT) ? {6'h00, (state_q != VIA_IDLE), trap_pnd_q} :
    8'h00;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable and pending banks
  vintarb_flags u_en (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set_i({`VIA_NSRC{1'b0}}),
    .wr_en(en_wmask),
    .wr_val(wr_val),
    .flag_q(en_q)
  );

  // acknowledgement never clears pending; only software does
  vintarb_flags u_pnd (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .set_i(src_event),
    .wr_en(pnd_wmask),
    .wr_val(wr_val),
    .flag_q(pnd_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // arbitration
  wire logic [`VIA_NSRC-1:0] active;
  wire logic [`VIA_NSLOT-1:0] slot_req;
  wire logic [3:0] slot;
  wire logic mask_ok;
  wire logic take_mask;
  wire logic take_now;
  wire logic take_trap;

  assign active = en_q & pnd_q;
  // slot 0 default, slots 1..13 maskable, 14 reserved, 15 trap
  assign slot_req = {trap_pnd_q, 1'b0, active, 1'b0};
  vintarb_rank u_rank (
    .req(slot_req),
    .slot(slot)
  );

  assign mask_ok = gie_q && !trap_pnd_q && (|active);
  // only at a normal instruction start, after a skip, outside boot rom
  assign take_now = instr_start && !skip_next && !in_boot_rom
                    && (state_q == VIA_IDLE);
  assign take_trap = take_now && trap_due_q;
  assign take_mask = take_now && !trap_due_q && mask_ok;

  ////////////////////////////////////////////////////////////////////////
  // vector table address
  wire logic [6:0] tbl_blk;
  wire logic [`VIA_AW-1:0] vec_hi_addr;

  // a vector select at a block's last byte uses the next block
  assign tbl_blk = (vis_pc[7:0] == `VIA_BLK_LAST) ? (vis_pc[14:8] + 7'h01)
                                                  : vis_pc[14:8];
  assign vec_hi_addr = {tbl_blk, `VIA_TBL_BASE | {3'h0, slot, 1'b0}};

  ////////////////////////////////////////////////////////////////////////
  // global enable and trap pending
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gie_q <= 1'b0;
    end else if (take_mask) begin
      gie_q <= 1'b0;
    end else if (return_from_irq_instruction_exec) begin
      gie_q <= 1'b1;
    end else if (wr_psr) begin
      gie_q <= reg_wdata[`VIA_PSR_GIE];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_pnd_q <= 1'b0;
    end else if (trap_exec) begin
      trap_pnd_q <= 1'b1;
    end else if (clear_trap_pending_instruction_exec) begin
      trap_pnd_q <= 1'b0;
    end
  end

  // trap still owed an acknowledge sequence
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_due_q <= 1'b0;
    end else if (trap_exec) begin
      trap_due_q <= 1'b1;
    end else if (take_trap) begin
      trap_due_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  vintarb_state_t state_d;
  logic [2:0] ack_cnt_d;

  always_comb begin
    state_d = state_q;
    ack_cnt_d = ack_cnt_q;
    unique case (state_q)
      VIA_IDLE: begin
        if (take_trap || take_mask) begin
          state_d = VIA_ACK;
          ack_cnt_d = 3'h1;
        end else if (vis_exec) begin
          state_d = VIA_VEC_HI;
        end
      end
      VIA_ACK: begin
        ack_cnt_d = ack_cnt_q + 3'h1;
        if (ack_cnt_q == `VIA_ACK_CYCLES - 3'h1) begin
          state_d = VIA_IDLE;
          ack_cnt_d = 3'h0;
        end
      end
      VIA_VEC_HI: state_d = VIA_VEC_LO;
      VIA_VEC_LO: state_d = VIA_VEC_JMP;
      VIA_VEC_JMP: state_d = VIA_IDLE;
      default: state_d = VIA_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= VIA_IDLE;
      ack_cnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      ack_cnt_q <= ack_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack, program counter and memory requests
  wire logic ack_done;
  wire logic vis_start;

  // fire one count early so the registered load lands in the seventh cycle
  assign ack_done = (state_q == VIA_ACK) && (ack_cnt_q == `VIA_ACK_CYCLES - 3'h2);
  assign vis_start = (state_q == VIA_IDLE) && !take_trap && !take_mask && vis_exec;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      push_req <= 1'b0;
      push_addr <= '0;
      pop_req <= 1'b0;
      ack_busy <= 1'b0;
    end else begin
      push_req <= take_trap || take_mask;
      pop_req <= return_from_irq_instruction_exec;
      ack_busy <= (state_d == VIA_ACK);
      if (take_trap || take_mask) begin
        push_addr <= cur_pc;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_load <= 1'b0;
      pc_load_addr <= '0;
    end else begin
      pc_load <= ack_done || (state_q == VIA_VEC_JMP);
      if (ack_done) begin
        pc_load_addr <= `VIA_SVC_ADDR;
      end else if (state_q == VIA_VEC_JMP) begin
        pc_load_addr <= {vec_hi_q[6:0], pm_rd_data};
      end
    end
  end

  // two reads: high byte first, then its successor
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pm_rd_req <= 1'b0;
      pm_rd_addr <= '0;
      vec_addr_q <= '0;
    end else begin
      pm_rd_req <= vis_start || (state_q == VIA_VEC_HI);
      if (vis_start) begin
        pm_rd_addr <= vec_hi_addr;
        vec_addr_q <= vec_hi_addr;
      end else if (state_q == VIA_VEC_HI) begin
        pm_rd_addr <= vec_addr_q + 15'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_hi_q <= 8'h00;
    end else if (state_q == VIA_VEC_LO) begin
      vec_hi_q <= pm_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_ack_pc_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (take_trap || take_mask) |-> ##6 (pc_load && pc_load_addr == `VIA_SVC_ADDR))
    else $error("acknowledge did not load the service address");

  a_ack_seven: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (take_trap || take_mask) |=> ack_busy [*6] ##1 !ack_busy)
    else $error("acknowledge sequence length wrong");

  a_ack_gie_push: assert property (@(posedge ref_clk) disable iff (!rst_b)
    take_mask |=> (!gie_q && push_req && push_addr == $past(cur_pc)))
    else $error("acknowledge did not clear enable or push");

  a_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (push_req && !$past(trap_due_q))
      |-> $past(gie_q && !trap_pnd_q && ((en_q & pnd_q) != '0)))
    else $error("maskable taken without qualification");

  a_no_boot_take: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (in_boot_rom || skip_next || !instr_start) |=> !push_req)
    else $error("acknowledge outside a normal instruction start");

  a_pend_kept: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (push_req && !$past(reg_wr)) |-> (($past(pnd_q) & ~pnd_q) == '0))
    else $error("acknowledge changed a pending flag");

  a_event_sets: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (src_event != '0) |=> ((pnd_q & $past(src_event)) == $past(src_event)))
    else $error("event did not set its pending flag");

  a_trap_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (trap_pnd_q && !clear_trap_pending_instruction_exec) |=> trap_pnd_q)
    else $error("trap pending cleared without clear-trap");

  a_trap_vector: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (vis_start && trap_pnd_q) |=> (pm_rd_req && pm_rd_addr[7:0] == 8'hfe))
    else $error("trap did not select the top slot");

  a_default_vec: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (vis_start && !trap_pnd_q && (en_q & pnd_q) == '0)
      |=> (pm_rd_addr[7:0] == `VIA_TBL_BASE))
    else $error("idle vector select missed default entry");

  a_vec_jump: assert property (@(posedge ref_clk) disable iff (!rst_b)
    vis_start |=> ##3 (pc_load && pc_load_addr == {vec_hi_q[6:0], $past(pm_rd_data)}))
    else $error("vector jump target wrong");

  a_return_from_irq_instruction_gie: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (return_from_irq_instruction_exec && !take_mask) |=> (gie_q && pop_req))
    else $error("return did not re-enable and pop");

  a_psr_nest: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_psr && reg_wdata[`VIA_PSR_GIE] && !take_mask) |=> gie_q)
    else $error("status write did not set global enable");

endmodule
`default_nettype wire

// file: testbench/vintarb_pmem.sv
// vintarb_pmem.sv: program memory model answering vector table fetches
// assumes a byte is wanted the cycle after each cycle of pm_rd_req
`timescale 1ns/1ns
`default_nettype none
module vintarb_pmem (
  // clock
  input wire logic ref_clk,
  // read request
  input wire logic pm_rd_req,
  input wire logic [14:0] pm_rd_addr,
  // read data
  output logic [7:0] pm_rd_data
);
  initial pm_rd_data = 8'h00;
  // fixed contents; outside a fetch the bus toggles so stale data never passes
  always @(posedge ref_clk) begin
    if (pm_rd_req) begin
      pm_rd_data <= pm_rd_addr[7:0] ^ 8'h5a;
    end else begin
      pm_rd_data <= ~pm_rd_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_vectored_interrupt_arbiter.sv
// test_vectored_interrupt_arbiter.sv: self-checking bench of the arbiter top
// assumes the program memory model and design files are compiled before it
`timescale 1ns/1ns
`default_nettype none
module test_vectored_interrupt_arbiter;
  logic ref_clk, rst_b, reg_wr, reg_rd, instr_start, skip_next, in_boot_rom;
  logic trap_exec, vis_exec, return_from_irq_instruction_exec, clear_trap_pending_instruction_exec, push_req, pop_req;
  logic pc_load, ack_busy, pm_rd_req;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pm_rd_data;
  logic [12:0] src_event;
  logic [14:0] cur_pc, vis_pc, push_addr, pc_load_addr, pm_rd_addr;
  int bad_count, check_count, cyc;

  vintarb dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .src_event, .instr_start, .skip_next, .in_boot_rom, .cur_pc,
    .trap_exec, .vis_exec, .vis_pc, .return_from_irq_instruction_exec, .clear_trap_pending_instruction_exec, .push_req,
    .push_addr, .pop_req, .pc_load, .pc_load_addr, .ack_busy, .pm_rd_req,
    .pm_rd_addr, .pm_rd_data);
  vintarb_pmem pmem (.ref_clk, .pm_rd_req, .pm_rd_addr, .pm_rd_data);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic s, input logic e);
    check({15'h0, s}, {15'h0, e});
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h0, reg_rdata}, {8'h0, e});
  endtask

  // one-cycle pulse of {clear_trap_pending_instruction, return_from_irq_instruction, vis, trap}
  task automatic core(input logic [3:0] w);
    @(posedge ref_clk);
    {clear_trap_pending_instruction_exec, return_from_irq_instruction_exec, vis_exec, trap_exec} <= w;
    @(posedge ref_clk);
    {clear_trap_pending_instruction_exec, return_from_irq_instruction_exec, vis_exec, trap_exec} <= 4'h0;
  endtask

  task automatic ev(input logic [12:0] v);
    @(posedge ref_clk);
    src_event <= v;
    @(posedge ref_clk);
    src_event <= 13'h0;
  endtask

  // instruction start, then watch seven cycles of the acknowledge sequence
  task automatic ack(input logic [14:0] pc, input logic e);
    @(posedge ref_clk);
    cur_pc <= pc;
    instr_start <= 1'b1;
    @(posedge ref_clk);
    instr_start <= 1'b0;
    for (int i = 1; i <= 7; i++) begin
      if (i > 1) @(posedge ref_clk);
      #1;
      chk1(push_req, e && i == 1);
      chk1(pc_load, e && i == 6);
      chk1(ack_busy, e && i <= 6);
      if (e && i == 1) check({1'b0, push_addr}, {1'b0, pc});
      if (e && i == 6) check({1'b0, pc_load_addr}, 16'h00ff);
    end
  endtask

  task automatic vector_select_instruction(input logic [14:0] pc, input logic [3:0] slot);
    logic [14:0] a;
    logic [7:0] hi;
    a = {pc[14:8] + 7'(pc[7:0] == 8'hff), 8'he0 + {3'h0, slot, 1'b0}};
    hi = a[7:0] ^ 8'h5a;
    @(posedge ref_clk);
    vis_pc <= pc;
    vis_exec <= 1'b1;
    @(posedge ref_clk);
    vis_exec <= 1'b0;
    #1;
    chk1(pm_rd_req, 1'b1);
    check({1'b0, pm_rd_addr}, {1'b0, a});
    @(posedge ref_clk);
    #1;
    check({1'b0, pm_rd_addr}, {1'b0, a + 15'h1});
    repeat (2) @(posedge ref_clk);
    #1;
    chk1(pc_load, 1'b1);
    check({1'b0, pc_load_addr}, {1'b0, hi[6:0], hi ^ 8'h01});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00);
  endtask

  task automatic t_enable();
    ev(13'h1001);
    rd(3'h2, 8'h01);
    rd(3'h3, 8'h10);
    ack(15'h0123, 1'b0);
    wr(3'h4, 8'h01);
    ack(15'h0123, 1'b0);
    wr(3'h0, 8'h01);
    ack(15'h0123, 1'b1);
    rd(3'h4, 8'h00);
    rd(3'h2, 8'h01);
    ack(15'h0124, 1'b0);
    wr(3'h4, 8'h01);
    ack(15'h0200, 1'b1);
  endtask

  task automatic t_block();
    wr(3'h4, 8'h01);
    @(posedge ref_clk);
    skip_next <= 1'b1;
    ack(15'h0300, 1'b0);
    @(posedge ref_clk);
    skip_next <= 1'b0;
    in_boot_rom <= 1'b1;
    ack(15'h0300, 1'b0);
    @(posedge ref_clk);
    in_boot_rom <= 1'b0;
    rd(3'h4, 8'h01);
    ack(15'h0301, 1'b1);
  endtask

  task automatic t_vis();
    wr(3'h1, 8'h10);
    vector_select_instruction(15'h0105, 4'd13);
    rd(3'h2, 8'h01);
    wr(3'h3, 8'h00);
    vector_select_instruction(15'h02ff, 4'd1);
    wr(3'h2, 8'h00);
    ev(13'h0002);
    vector_select_instruction(15'h0310, 4'd0);
  endtask

  task automatic t_trap();
    wr(3'h2, 8'h01);
    wr(3'h4, 8'h01);
    core(4'h1);
    rd(3'h5, 8'h01);
    ack(15'h0400, 1'b1);
    rd(3'h4, 8'h01);
    vector_select_instruction(15'h0500, 4'd15);
    ack(15'h0401, 1'b0);
    core(4'h8);
    rd(3'h5, 8'h00);
    ack(15'h0402, 1'b1);
  endtask

  task automatic t_return_from_irq_instruction();
    core(4'h4);
    #1;
    chk1(pop_req, 1'b1);
    rd(3'h4, 8'h01);
    ack(15'h0600, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, reg_wr, reg_rd, instr_start, skip_next, in_boot_rom} = 6'h0;
    {trap_exec, vis_exec, return_from_irq_instruction_exec, clear_trap_pending_instruction_exec} = 4'h0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    src_event = 13'h0;
    cur_pc = 15'h0;
    vis_pc = 15'h0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_enable();
    t_block();
    t_vis();
    t_trap();
    t_return_from_irq_instruction();
    finish_test();
  end
endmodule
`default_nettype wire
